// File: design/jtsdr_map.vh
`ifndef JTSDR_MAP_VH
`define JTSDR_MAP_VH

// Instruction codes
`define JTSDR_IR_W 4
`define JTSDR_IR_EXTEST 4'h1
`define JTSDR_IR_SAMPLE 4'h2
`define JTSDR_IR_IDCODE 4'h3
`define JTSDR_IR_CLAMP 4'h4
`define JTSDR_IR_HIGHZ 4'h5
`define JTSDR_IR_DBGLINK 4'h7
`define JTSDR_IR_BYPASS 4'hf
`define JTSDR_IR_CAPTURE 4'h1

// Data register widths
`define JTSDR_DBG_W 9
`define JTSDR_ID_W 32
`define JTSDR_VER_W 4
`define JTSDR_PART_W 16
`define JTSDR_MFR_W 11
`define JTSDR_ID_LSB 1'b1

// Tap controller states
`define JTSDR_ST_W 4
`define JTSDR_ST_TLR 4'h0
`define JTSDR_ST_RTI 4'h1
`define JTSDR_ST_SEL_DR 4'h2
`define JTSDR_ST_CAP_DR 4'h3
`define JTSDR_ST_SH_DR 4'h4
`define JTSDR_ST_EX1_DR 4'h5
`define JTSDR_ST_PAU_DR 4'h6
`define JTSDR_ST_EX2_DR 4'h7
`define JTSDR_ST_UPD_DR 4'h8
`define JTSDR_ST_SEL_IR 4'h9
`define JTSDR_ST_CAP_IR 4'ha
`define JTSDR_ST_SH_IR 4'hb
`define JTSDR_ST_EX1_IR 4'hc
`define JTSDR_ST_PAU_IR 4'hd
`define JTSDR_ST_EX2_IR 4'he
`define JTSDR_ST_UPD_IR 4'hf

`endif

// File: design/jtsdr_sync.v
`timescale 1ns/10ps
module jtsdr_sync #(
    parameter W = 1
) (
    input wire i_mclk,
    input wire i_srst,
    input wire [W-1:0] i_async,
    output wire [W-1:0] o_sync
);
    reg [W-1:0] meta_q;
    reg [W-1:0] sync_q;

    // First stage feeds only the second
    always @(posedge i_mclk) begin
        if (i_srst) begin
            meta_q <= {W{1'b0}};
            sync_q <= {W{1'b0}};
        end else begin
            meta_q <= i_async;
            sync_q <= meta_q;
        end
    end

    assign o_sync = sync_q;
endmodule // jtsdr_sync

// File: design/jtsdr_bchain.v
`timescale 1ns/10ps
module jtsdr_bchain #(
    parameter NPIN = 8
) (
    input wire i_mclk,
    input wire i_srst,
    input wire i_capture,
    input wire i_shift,
    input wire i_update,
    input wire i_mode,
    input wire i_highz,
    input wire i_si,
    input wire [NPIN-1:0] i_core_dir,
    input wire [NPIN-1:0] i_core_out,
    input wire [NPIN-1:0] i_pad_in,
    input wire i_dbg_clock_reset_pad,
    input wire i_dbg_serial_line,
    output wire o_so,
    output reg [NPIN-1:0] o_pad_oe,
    output reg [NPIN-1:0] o_pad_out
);
    localparam LEN = 2 * NPIN + 2;

    reg [LEN-1:0] shift_q;
    reg [2*NPIN-1:0] upd_q;
    reg [LEN-1:0] cap_w;
    integer i;
    integer j;

    // Per pin: even bit is direction, odd bit is level; two pad cells last
    always @* begin
        cap_w = {LEN{1'b0}};
        for (i = 0; i < NPIN; i = i + 1) begin
            cap_w[2*i] = i_core_dir[i];
            cap_w[2*i+1] = i_pad_in[i];
        end
        cap_w[LEN-2] = i_dbg_clock_reset_pad;
        cap_w[LEN-1] = i_dbg_serial_line;
    end

    always @(posedge i_mclk) begin
        if (i_srst) begin
            shift_q <= {LEN{1'b0}};
            upd_q <= {(2*NPIN){1'b0}};
        end else begin
            if (i_capture) begin
                shift_q <= cap_w;
            end else if (i_shift) begin
                shift_q <= {i_si, shift_q[LEN-1:1]};
            end
            // Observe-only cells have no update stage
            if (i_update) begin
                upd_q <= shift_q[2*NPIN-1:0];
            end
        end
    end

    always @(posedge i_mclk) begin
        if (i_srst) begin
            o_pad_oe <= {NPIN{1'b0}};
            o_pad_out <= {NPIN{1'b0}};
        end else begin
            for (j = 0; j < NPIN; j = j + 1) begin
                if (i_highz) begin
                    o_pad_oe[j] <= 1'b0;
                    o_pad_out[j] <= 1'b0;
                end else if (i_mode) begin
                    o_pad_oe[j] <= upd_q[2*j];
                    o_pad_out[j] <= upd_q[2*j+1];
                end else begin
                    o_pad_oe[j] <= i_core_dir[j];
                    o_pad_out[j] <= i_core_out[j];
                end
            end
        end
    end

    assign o_so = shift_q[0];
endmodule // jtsdr_bchain

// File: design/jtsdr_top.v
// How it works
// - Code 0xf puts the one-bit bypass register between TDI and TDO.
// - Code 0x4 drives pins from preloaded latches, scan path through bypass.
// - Code 0x5 turns every output off and selects bypass.
// - Bypass cleared at capture-DR, shifted one step per shift-DR edge.
// - Debug-link code 0x7 captures debug interface data at capture-DR.
// - Debug-link register shifts on TCK in shift-DR.
// - Update-DR hands the debug-link contents to the debug interface.
// - Debug-link register is 9 bits, serial to parallel both ways.
// - Extest, clamp or highz holds the core in reset.
// - That reset stops oscillators, analog parts, resets pin options.
// - Sample/preload leaves device and pin state alone.
// - Each bidirectional pin cell controls and observes direction and level.
// - Normal pins take drive enable and value from core registers.
// - Cell mode only under clamp or extest; shift follows shift-DR.
// - Observe-only cells for the clock/reset pad and serial line pad.
// - Serial line pad is observe-only, no logic in its output path.
// - Four data registers: bypass, identification, boundary, debug link.
// - Identification carries a 4-bit version, first revision 0x0.
// - Identification carries a 16-bit part number.
// - Identification carries an 11-bit manufacturer code.
// - Instruction register is four bits; everything shifts lsb first.
// - After reset the identification instruction 0x3 is selected.
// - Identification register is 32 bits: version, part, maker, then a fixed 1 lsb.
`timescale 1ns/10ps
`include "jtsdr_map.vh"

module jtsdr_top #(
    parameter NPIN = 8,
    parameter [`JTSDR_VER_W-1:0] VERSION = 4'h0,
    // Arbitrary neutral value
    parameter [`JTSDR_PART_W-1:0] PART_NUMBER = 16'h1234,
    // Arbitrary neutral value
    parameter [`JTSDR_MFR_W-1:0] MANUFACTURER = 11'h2aa
) (
    input wire i_mclk,
    input wire i_srst,
    input wire i_tck,
    input wire i_tms,
    input wire i_tdi,
    output reg o_tdo,
    output reg o_tdo_oe,
    input wire [NPIN-1:0] i_core_dir,
    input wire [NPIN-1:0] i_core_out,
    input wire [NPIN-1:0] i_pad_in,
    output wire [NPIN-1:0] o_pad_oe,
    output wire [NPIN-1:0] o_pad_out,
    input wire i_dbg_clock_reset_pad,
    input wire i_dbg_serial_line,
    input wire [`JTSDR_DBG_W-1:0] i_dbg_capture_data,
    output reg [`JTSDR_DBG_W-1:0] o_dbg_update_data,
    output reg o_dbg_update_stb,
    output reg o_dbg_capture_stb,
    output wire o_core_reset,
    output wire o_ext_osc_disable,
    output wire o_analog_disable,
    output wire o_pin_opt_default,
    output wire [`JTSDR_IR_W-1:0] o_instr
);
    // Data register selectors
    localparam SEL_BYPASS = 2'h0;
    localparam SEL_IDCODE = 2'h1;
    localparam SEL_BSCAN = 2'h2;
    localparam SEL_DBG = 2'h3;

    wire [NPIN+4:0] pin_sync;
    wire tck_s;
    wire tms_s;
    wire tdi_s;
    wire [NPIN-1:0] pad_in_s;
    wire dbg_clk_s;
    wire dbg_dat_s;
    wire bs_so;
    wire tck_rise;
    wire tck_fall;
    wire cap_dr;
    wire sh_dr;
    wire upd_dr;
    wire [1:0] sel;
    wire bs_mode;
    wire bs_highz;
    wire bs_active;

    reg tck_q;
    reg [`JTSDR_ST_W-1:0] st_q;
    reg [`JTSDR_ST_W-1:0] st_d;
    reg [`JTSDR_IR_W-1:0] ir_sh_q;
    reg [`JTSDR_IR_W-1:0] ir_q;
    reg bypass_q;
    reg [`JTSDR_ID_W-1:0] id_q;
    reg [`JTSDR_DBG_W-1:0] dbg_q;
    reg force_rst_q;
    reg tdo_d;

    // Every pin, the test clock included, is sampled twice before use
    jtsdr_sync #(
        .W(NPIN + 5)
    ) u_sync (
        .i_mclk(i_mclk),
        .i_srst(i_srst),
        .i_async({i_dbg_serial_line, i_dbg_clock_reset_pad, i_pad_in, i_tdi, i_tms, i_tck}),
        .o_sync(pin_sync)
    );

    assign tck_s = pin_sync[0];
    assign tms_s = pin_sync[1];
    assign tdi_s = pin_sync[2];
    assign pad_in_s = pin_sync[NPIN+2:3];
    assign dbg_clk_s = pin_sync[NPIN+3];
    assign dbg_dat_s = pin_sync[NPIN+4];

    always @(posedge i_mclk) begin
        if (i_srst) begin
            tck_q <= 1'b0;
        end else begin
            tck_q <= tck_s;
        end
    end

    assign tck_rise = tck_s & ~tck_q;
    assign tck_fall = ~tck_s & tck_q;

    // Standard sixteen-state controller, advanced on each rising test clock
    function [`JTSDR_ST_W-1:0] tap_next;
        input [`JTSDR_ST_W-1:0] s;
        input tms;
        begin
            case (s)
                `JTSDR_ST_TLR: tap_next = tms ? `JTSDR_ST_TLR : `JTSDR_ST_RTI;
                `JTSDR_ST_RTI: tap_next = tms ? `JTSDR_ST_SEL_DR : `JTSDR_ST_RTI;
                `JTSDR_ST_SEL_DR: tap_next = tms ? `JTSDR_ST_SEL_IR : `JTSDR_ST_CAP_DR;
                `JTSDR_ST_CAP_DR: tap_next = tms ? `JTSDR_ST_EX1_DR : `JTSDR_ST_SH_DR;
                `JTSDR_ST_SH_DR: tap_next = tms ? `JTSDR_ST_EX1_DR : `JTSDR_ST_SH_DR;
                `JTSDR_ST_EX1_DR: tap_next = tms ? `JTSDR_ST_UPD_DR : `JTSDR_ST_PAU_DR;
                `JTSDR_ST_PAU_DR: tap_next = tms ? `JTSDR_ST_EX2_DR : `JTSDR_ST_PAU_DR;
                `JTSDR_ST_EX2_DR: tap_next = tms ? `JTSDR_ST_UPD_DR : `JTSDR_ST_SH_DR;
                `JTSDR_ST_UPD_DR: tap_next = tms ? `JTSDR_ST_SEL_DR : `JTSDR_ST_RTI;
                `JTSDR_ST_SEL_IR: tap_next = tms ? `JTSDR_ST_TLR : `JTSDR_ST_CAP_IR;
                `JTSDR_ST_CAP_IR: tap_next = tms ? `JTSDR_ST_EX1_IR : `JTSDR_ST_SH_IR;
                `JTSDR_ST_SH_IR: tap_next = tms ? `JTSDR_ST_EX1_IR : `JTSDR_ST_SH_IR;
                `JTSDR_ST_EX1_IR: tap_next = tms ? `JTSDR_ST_UPD_IR : `JTSDR_ST_PAU_IR;
                `JTSDR_ST_PAU_IR: tap_next = tms ? `JTSDR_ST_EX2_IR : `JTSDR_ST_PAU_IR;
                `JTSDR_ST_EX2_IR: tap_next = tms ? `JTSDR_ST_UPD_IR : `JTSDR_ST_SH_IR;
                `JTSDR_ST_UPD_IR: tap_next = tms ? `JTSDR_ST_SEL_DR : `JTSDR_ST_RTI;
                default: tap_next = `JTSDR_ST_TLR;
            endcase
        end
    endfunction

    // Which data register an instruction places between TDI and TDO
    function [1:0] dr_select;
        input [`JTSDR_IR_W-1:0] ir;
        begin
            case (ir)
                `JTSDR_IR_IDCODE: dr_select = SEL_IDCODE;
                `JTSDR_IR_EXTEST: dr_select = SEL_BSCAN;
                `JTSDR_IR_SAMPLE: dr_select = SEL_BSCAN;
                `JTSDR_IR_DBGLINK: dr_select = SEL_DBG;
                `JTSDR_IR_BYPASS: dr_select = SEL_BYPASS;
                `JTSDR_IR_CLAMP: dr_select = SEL_BYPASS;
                `JTSDR_IR_HIGHZ: dr_select = SEL_BYPASS;
                default: dr_select = SEL_BYPASS;
            endcase
        end
    endfunction

    always @* begin
        st_d = st_q;
        if (tck_rise) begin
            st_d = tap_next(st_q, tms_s);
        end
    end

    always @(posedge i_mclk) begin
        if (i_srst) begin
            st_q <= `JTSDR_ST_TLR;
        end else begin
            st_q <= st_d;
        end
    end

    // Actions fire on the rising test clock that leaves the state
    assign cap_dr = tck_rise & (st_q == `JTSDR_ST_CAP_DR);
    assign sh_dr = tck_rise & (st_q == `JTSDR_ST_SH_DR);
    assign upd_dr = tck_rise & (st_q == `JTSDR_ST_UPD_DR);
    assign sel = dr_select(ir_q);

    // Instruction register, four bits, lsb out first
    always @(posedge i_mclk) begin
        if (i_srst) begin
            ir_sh_q <= `JTSDR_IR_CAPTURE;
            ir_q <= `JTSDR_IR_IDCODE;
        end else if (tck_rise) begin
            if (st_q == `JTSDR_ST_TLR) begin
                ir_q <= `JTSDR_IR_IDCODE;
            end else if (st_q == `JTSDR_ST_CAP_IR) begin
                ir_sh_q <= `JTSDR_IR_CAPTURE;
            end else if (st_q == `JTSDR_ST_SH_IR) begin
                ir_sh_q <= {tdi_s, ir_sh_q[`JTSDR_IR_W-1:1]};
            end else if (st_q == `JTSDR_ST_UPD_IR) begin
                ir_q <= ir_sh_q;
            end
        end
    end

    // Bypass cell
    always @(posedge i_mclk) begin
        if (i_srst) begin
            bypass_q <= 1'b0;
        end else if (sel == SEL_BYPASS) begin
            if (cap_dr) begin
                bypass_q <= 1'b0;
            end else if (sh_dr) begin
                bypass_q <= tdi_s;
            end
        end
    end

    // Identification register
    always @(posedge i_mclk) begin
        if (i_srst) begin
            id_q <= {`JTSDR_ID_W{1'b0}};
        end else if (sel == SEL_IDCODE) begin
            if (cap_dr) begin
                id_q <= {VERSION, PART_NUMBER, MANUFACTURER, `JTSDR_ID_LSB};
            end else if (sh_dr) begin
                id_q <= {tdi_s, id_q[`JTSDR_ID_W-1:1]};
            end
        end
    end

    // Debug link register; strobes are one system clock long
    always @(posedge i_mclk) begin
        if (i_srst) begin
            dbg_q <= {`JTSDR_DBG_W{1'b0}};
            o_dbg_update_data <= {`JTSDR_DBG_W{1'b0}};
            o_dbg_update_stb <= 1'b0;
            o_dbg_capture_stb <= 1'b0;
        end else begin
            o_dbg_update_stb <= 1'b0;
            o_dbg_capture_stb <= 1'b0;
            if (sel == SEL_DBG) begin
                if (cap_dr) begin
                    dbg_q <= i_dbg_capture_data;
                    o_dbg_capture_stb <= 1'b1;
                end else if (sh_dr) begin
                    dbg_q <= {tdi_s, dbg_q[`JTSDR_DBG_W-1:1]};
                end else if (upd_dr) begin
                    o_dbg_update_data <= dbg_q;
                    o_dbg_update_stb <= 1'b1;
                end
            end
        end
    end

    // Sample/preload touches neither mode nor reset
    assign bs_active = (sel == SEL_BSCAN);
    assign bs_mode = (ir_q == `JTSDR_IR_EXTEST) | (ir_q == `JTSDR_IR_CLAMP);
    assign bs_highz = (ir_q == `JTSDR_IR_HIGHZ);

    jtsdr_bchain #(
        .NPIN(NPIN)
    ) u_bchain (
        .i_mclk(i_mclk),
        .i_srst(i_srst),
        .i_capture(cap_dr & bs_active),
        .i_shift(sh_dr & bs_active),
        .i_update(upd_dr & bs_active),
        .i_mode(bs_mode),
        .i_highz(bs_highz),
        .i_si(tdi_s),
        .i_core_dir(i_core_dir),
        .i_core_out(i_core_out),
        .i_pad_in(pad_in_s),
        .i_dbg_clock_reset_pad(dbg_clk_s),
        .i_dbg_serial_line(dbg_dat_s),
        .o_so(bs_so),
        .o_pad_oe(o_pad_oe),
        .o_pad_out(o_pad_out)
    );

    // Core reset and the defaults that go with it
    always @(posedge i_mclk) begin
        if (i_srst) begin
            force_rst_q <= 1'b0;
        end else begin
            force_rst_q <= bs_mode | bs_highz;
        end
    end

    assign o_core_reset = force_rst_q;
    assign o_ext_osc_disable = force_rst_q;
    assign o_analog_disable = force_rst_q;
    assign o_pin_opt_default = force_rst_q;
    assign o_instr = ir_q;

    // Output mux; lsb of the selected path
    always @* begin
        case (sel)
            SEL_IDCODE: tdo_d = id_q[0];
            SEL_BSCAN: tdo_d = bs_so;
            SEL_DBG: tdo_d = dbg_q[0];
            default: tdo_d = bypass_q;
        endcase
        if (st_q == `JTSDR_ST_SH_IR) begin
            tdo_d = ir_sh_q[0];
        end
    end

    // TDO changes on the falling test clock so the tester samples it stable
    always @(posedge i_mclk) begin
        if (i_srst) begin
            o_tdo <= 1'b0;
            o_tdo_oe <= 1'b0;
        end else if (tck_fall) begin
            o_tdo <= tdo_d;
            o_tdo_oe <= (st_q == `JTSDR_ST_SH_DR) | (st_q == `JTSDR_ST_SH_IR);
        end
    end
endmodule // jtsdr_top

// File: tb/jtsdr_tester.sv
`timescale 1ns/10ps
module jtsdr_tester (
    input wire logic i_mclk,
    output logic o_tck,
    output logic o_tms,
    output logic o_tdi,
    input wire logic i_tdo
);
    realtime t_last = -1.0;
    initial begin
        o_tck = 1'b0;
        o_tms = 1'b1;
        o_tdi = 1'b0;
    end
    // Tck stands low between calls, so it only runs inside frames
    task automatic step(input logic tms, input logic tdi, output logic tdo);
        // Fresh frame moved off both system edges; 125 ns steps then stay off
        if ($realtime != t_last) begin
            @(negedge i_mclk);
            #1.25;
        end
        o_tms = tms;
        o_tdi = tdi;
        #62.5 o_tck = 1'b1;
        tdo = i_tdo;
        #62.5 o_tck = 1'b0;
        t_last = $realtime;
    endtask
    // Nobody reads tdi here, so it toggles rather than hold a stale bit
    task automatic walk(input logic [7:0] seq, input int n);
        logic d;
        for (int i = n - 1; i >= 0; i--) begin
            step(seq[i], ~o_tdi, d);
        end
    endtask
    task automatic scan(input logic ir, input int n, input logic [63:0] din,
            output logic [63:0] dout);
        dout = '0;
        if (ir) begin
            walk(8'h0c, 4);
        end else begin
            walk(8'h04, 3);
        end
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], dout[i]);
        end
        walk(8'h02, 2);
    endtask
endmodule // jtsdr_tester

// File: tb/jtsdr_top_asserts.sv
`timescale 1ns/10ps
module jtsdr_top_asserts #(
    parameter int NPIN = 8
) (
    input wire logic i_mclk,
    input wire logic i_srst,
    input wire logic i_tck,
    input wire logic o_tdo,
    input wire logic o_tdo_oe,
    input wire logic [NPIN-1:0] i_core_dir,
    input wire logic [NPIN-1:0] i_core_out,
    input wire logic [NPIN-1:0] o_pad_oe,
    input wire logic [NPIN-1:0] o_pad_out,
    input wire logic [8:0] o_dbg_update_data,
    input wire logic o_dbg_update_stb,
    input wire logic o_dbg_capture_stb,
    input wire logic o_core_reset,
    input wire logic o_ext_osc_disable,
    input wire logic o_analog_disable,
    input wire logic o_pin_opt_default,
    input wire logic [3:0] o_instr
);
    default clocking @(posedge i_mclk);
    endclocking
    default disable iff (i_srst);

    a_core_hold: assert property (o_core_reset == ($past(o_instr) inside {4'h1, 4'h4, 4'h5}))
        else $error("core reset off its instruction");
    a_side_off: assert property (o_ext_osc_disable == o_core_reset &&
            o_analog_disable == o_core_reset && o_pin_opt_default == o_core_reset)
        else $error("side disables differ");
    a_highz_off: assert property (o_instr == 4'h5 [*2] |-> o_pad_oe == '0 && o_pad_out == '0)
        else $error("pad driven under highz");
    // Two cycles of margin, as pads lag the instruction by one register
    a_pads_follow: assert property (!$past(i_srst) && !(o_instr inside {4'h1, 4'h4, 4'h5}) &&
            !($past(o_instr) inside {4'h1, 4'h4, 4'h5})
            |-> o_pad_oe == $past(i_core_dir) && o_pad_out == $past(i_core_out))
        else $error("pads not following core");
    a_clamp_hold: assert property (o_instr == 4'h4 [*3] |-> $stable(o_pad_oe) && $stable(o_pad_out))
        else $error("pads moved under clamp");
    a_capture_pulse: assert property (o_dbg_capture_stb |-> o_instr == 4'h7 ##1 !o_dbg_capture_stb)
        else $error("bad capture strobe");
    a_update_pulse: assert property (o_dbg_update_stb |-> o_instr == 4'h7 ##1 !o_dbg_update_stb)
        else $error("bad update strobe");
    a_update_cause: assert property (!$past(i_srst) && !$stable(o_dbg_update_data)
            |-> o_dbg_update_stb)
        else $error("update data without strobe");
    a_tdo_on_fall: assert property (!$past(i_srst) && ($changed(o_tdo) || $changed(o_tdo_oe))
            |-> !i_tck)
        else $error("tdo moved with tck high");
    a_id_default: assert property ($fell(i_srst) |-> o_instr == 4'h3)
        else $error("no identification after reset");
endmodule // jtsdr_top_asserts

bind jtsdr_top jtsdr_top_asserts #(.NPIN(NPIN)) chk_u (
    .i_mclk, .i_srst, .i_tck, .o_tdo, .o_tdo_oe, .i_core_dir, .i_core_out, .o_pad_oe,
    .o_pad_out, .o_dbg_update_data, .o_dbg_update_stb, .o_dbg_capture_stb, .o_core_reset,
    .o_ext_osc_disable, .o_analog_disable, .o_pin_opt_default, .o_instr
);

// File: tb/jtsdr_top_tb.sv
`timescale 1ns/10ps
module jtsdr_top_tb;
    localparam int NPIN = 8;
    localparam int BSW = 2 * NPIN + 2;
    localparam logic [3:0] VER = 4'h1;
    localparam logic [15:0] PART = 16'h6c29; // Arbitrary value
    localparam logic [10:0] MFR = 11'h2d3; // Arbitrary value
    logic i_mclk, i_srst, i_tck, i_tms, i_tdi, o_tdo, o_tdo_oe;
    logic [NPIN-1:0] i_core_dir, i_core_out, i_pad_in, o_pad_oe, o_pad_out;
    logic i_dbg_clock_reset_pad, i_dbg_serial_line;
    logic [8:0] i_dbg_capture_data, o_dbg_update_data;
    logic o_dbg_update_stb, o_dbg_capture_stb, o_core_reset;
    logic o_ext_osc_disable, o_analog_disable, o_pin_opt_default;
    logic [3:0] o_instr;
    logic [63:0] din, dout, pre;
    logic [3:0] byp [12] = '{4'hf, 4'h4, 4'h5, 4'h0, 4'h6, 4'h8, 4'h9, 4'ha, 4'hb, 4'hc,
        4'hd, 4'he};
    int n_fail = 0;
    int cmp_count = 0;
    int seed = 6;
    int n_up = 0;
    int n_cap = 0;
    int n0;
    int c0;

    jtsdr_top #(.NPIN(NPIN), .VERSION(VER), .PART_NUMBER(PART), .MANUFACTURER(MFR)) dut_u (
        .i_mclk, .i_srst, .i_tck, .i_tms, .i_tdi, .o_tdo, .o_tdo_oe, .i_core_dir,
        .i_core_out, .i_pad_in, .o_pad_oe, .o_pad_out, .i_dbg_clock_reset_pad,
        .i_dbg_serial_line, .i_dbg_capture_data, .o_dbg_update_data, .o_dbg_update_stb,
        .o_dbg_capture_stb, .o_core_reset, .o_ext_osc_disable, .o_analog_disable,
        .o_pin_opt_default, .o_instr
    );
    // Released TDO shows the inverse, so a sample taken without drive fails
    jtsdr_tester tst_u (.i_mclk(i_mclk), .o_tck(i_tck), .o_tms(i_tms), .o_tdi(i_tdi),
        .i_tdo(o_tdo_oe ? o_tdo : ~o_tdo));

    initial begin
        i_mclk = 1'b0;
        forever #5 i_mclk = ~i_mclk;
    end
    always @(posedge i_mclk) begin
        if (o_dbg_update_stb === 1'b1) begin
            n_up <= n_up + 1;
        end
        if (o_dbg_capture_stb === 1'b1) begin
            n_cap <= n_cap + 1;
        end
    end

    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic results();
        $display("Compares %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    function automatic logic forced(input logic [3:0] c);
        return c inside {4'h1, 4'h4, 4'h5};
    endfunction
    function automatic logic [63:0] exp_bs();
        logic [63:0] b;
        b = '0;
        for (int i = 0; i < NPIN; i++) begin
            b[2*i] = i_core_dir[i];
            b[2*i+1] = i_pad_in[i];
        end
        b[BSW-2] = i_dbg_clock_reset_pad;
        b[BSW-1] = i_dbg_serial_line;
        return b;
    endfunction
    function automatic logic [63:0] exp_pads(input logic [63:0] q);
        logic [NPIN-1:0] oe, v;
        for (int i = 0; i < NPIN; i++) begin
            oe[i] = q[2*i];
            v[i] = q[2*i+1];
        end
        return 64'({oe, v});
    endfunction
    task automatic drive_core();
        @(negedge i_mclk);
        i_core_dir = NPIN'($random(seed));
        i_core_out = NPIN'($random(seed));
        i_pad_in = NPIN'($random(seed));
        i_dbg_clock_reset_pad = 1'($random(seed));
        i_dbg_serial_line = 1'($random(seed));
    endtask
    task automatic load(input logic [3:0] code);
        tst_u.scan(1'b1, 4, 64'(code), dout);
        check(dout, 64'h1);
        repeat (3) @(negedge i_mclk);
        check(o_instr, code);
        check(o_tdo_oe, 1'b0);
        check(o_core_reset, forced(code));
        check({o_ext_osc_disable, o_analog_disable, o_pin_opt_default}, {3{forced(code)}});
    endtask

    initial begin
        repeat (100000) @(posedge i_mclk);
        n_fail++;
        $display("CHECK FAILED at %0t: run too long", $time);
        results();
    end
    initial begin
        i_srst = 1'b1;
        {i_core_dir, i_core_out, i_pad_in} = '0;
        {i_dbg_clock_reset_pad, i_dbg_serial_line} = '0;
        i_dbg_capture_data = '0;
        repeat (8) @(posedge i_mclk);
        @(negedge i_mclk);
        i_srst = 1'b0;
        drive_core();
        repeat (4) @(negedge i_mclk);
        check(o_instr, 4'h3);
        check({o_pad_oe, o_pad_out}, {i_core_dir, i_core_out});
        tst_u.walk(8'h3e, 6);
        tst_u.scan(1'b0, 32, '1, dout);
        check(dout, {VER, PART, MFR, 1'b1});
        drive_core();
        load(4'h2);
        pre = 64'($random(seed));
        tst_u.scan(1'b0, BSW, pre, dout);
        check(dout, exp_bs());
        check({o_pad_oe, o_pad_out}, {i_core_dir, i_core_out});
        load(4'h1);
        check({o_pad_oe, o_pad_out}, exp_pads(pre));
        pre = 64'($random(seed));
        tst_u.scan(1'b0, BSW, pre, dout);
        drive_core();
        repeat (3) @(negedge i_mclk);
        check({o_pad_oe, o_pad_out}, exp_pads(pre));
        foreach (byp[k]) begin
            load(byp[k]);
            din = 64'($random(seed));
            tst_u.scan(1'b0, 3, din, dout);
            check(dout, 64'({din[1:0], 1'b0}));
            if (byp[k] == 4'h4) begin
                check({o_pad_oe, o_pad_out}, exp_pads(pre));
            end
            if (byp[k] == 4'h5) begin
                check({o_pad_oe, o_pad_out}, 64'h0);
            end
        end
        load(4'h7);
        // Back to back, no reload between, so update must not disturb capture
        for (int k = 0; k < 4; k++) begin
            @(negedge i_mclk);
            i_dbg_capture_data = (k == 0) ? 9'h1ff : 9'($random(seed));
            din = (k == 1) ? 64'h0 : 64'($random(seed));
            n0 = n_up;
            c0 = n_cap;
            tst_u.scan(1'b0, 9, din, dout);
            check(dout, 64'(i_dbg_capture_data));
            check(o_dbg_update_data, din[8:0]);
            check(n_up - n0, 1);
            check(n_cap - c0, 1);
        end
        // Five high TMS edges must bring back the identification code
        tst_u.walk(8'h3e, 6);
        repeat (3) @(negedge i_mclk);
        check(o_instr, 4'h3);
        check(o_core_reset, 1'b0);
        results();
    end
endmodule // jtsdr_top_tb
